// ### tolm_monitor.sv
// Temperature offset, limit, status and thermal-trip monitor with register file
// What this block does
// (R1) Add signed 8-bit offset, 0.25 C per step, to each temperature result.
// (R2) Remote 1, local and remote 2 offsets each reset to zero.
// (R3) Each temperature channel has high and low limits setting its status flag.
// (R4) A temperature limit violation can also drive the alert output low.
// (R5) Temperature low limits reset to 0x81, high limits to 0x7f.
// (R6) In automatic fan mode, any channel above its trip limit forces full fans.
// (R7) Full speed holds until temperature drops below trip limit minus hysteresis.
// (R8) Configuration 3 bit 2 disables that full-speed hold.
// (R9) Hysteresis comes from the two hysteresis registers, resetting to 4 C.
// (R10) Each thermal-trip limit resets to 0x64.
// (R11) By default each value is the average of 16 conversions.
// (R12) Configuration 2 bit 4 turns averaging off; a round then takes 15.5 ms.
// (R13) Unaveraged, remote conversions take 4 ms and local 1.4 ms.
// (R14) Configuration 2 bit 6 repeats conversion of one selected channel only.
// (R15) Fan 1 minimum high byte bits 7..5 select 101, 110 or 111.
// (R16) Voltage limits: low resets to 0x00, high resets to 0xff.
// (R17) Any out-of-limit channel sets a status bit; host polls or takes the alert.
// (R18) Temperatures are 10-bit two's complement, 0.25 C per step.
// (R19) High limit trips when strictly above; low limit when at or below.
// (R20) Status flags stick until read after the cause has gone.
// (R21) Comparisons use the offset-corrected value that is stored.
`timescale 1ns/1ns
`include "tolm_consts.svh"
module tolm_monitor #(
  parameter int REMOTE_CYC     = `TOLM_REMOTE_NS / `TOLM_CLK_NS,
  parameter int LOCAL_CYC      = `TOLM_LOCAL_NS / `TOLM_CLK_NS,
  parameter int VOLT_CYC       = `TOLM_VOLT_NS / `TOLM_CLK_NS,
  parameter int REMOTE_AVG_CYC = `TOLM_REMOTE_AVG_NS / `TOLM_CLK_NS / `TOLM_AVG_SAMPLES,
  parameter int LOCAL_AVG_CYC  = `TOLM_LOCAL_AVG_NS / `TOLM_CLK_NS / `TOLM_AVG_SAMPLES,
  parameter int VOLT_AVG_CYC   = `TOLM_VOLT_AVG_NS / `TOLM_CLK_NS / `TOLM_AVG_SAMPLES,
  parameter int ROUND_CYC      = `TOLM_ROUND_NS / `TOLM_CLK_NS,
  parameter int ROUND_AVG_CYC  = `TOLM_ROUND_AVG_NS / `TOLM_CLK_NS
) (
  // Clock and reset
  input  logic       i_clock,
  input  logic       i_rst,
  // Register port
  input  logic [7:0] i_reg_addr,
  input  logic       i_reg_wr,
  input  logic [7:0] i_reg_wdata,
  input  logic       i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Converter
  output logic       o_adc_start,
  output logic [2:0] o_adc_chan,
  input  logic [9:0] i_adc_data,
  // Fan and alert
  input  logic       i_auto_fan_mode,
  output logic       o_fan_full_speed,
  output logic       o_smbalert_n
);
  tolm_pkg::tolm_core_s r_r, r_nxt;
  tolm_conv_if cif ();

  logic [9:0] v_t;
  logic [7:0] v_v;
  logic [1:0] idx;
  logic [3:0] hyst;
  logic       hi;
  logic       lo;
  logic       above;
  logic       below;

  // Offset add with saturation so a large offset cannot wrap the sign
  function automatic logic [9:0] add_offs(input logic [9:0] raw, input logic [7:0] off);
    logic signed [10:0] s;
    s = $signed({raw[9], raw}) + $signed({{3{off[7]}}, off});
    if (s > 11'sd511)
      add_offs = 10'h1ff;
    else if (s < -11'sd512)
      add_offs = 10'h200;
    else
      add_offs = s[9:0];
  endfunction

  // Value above a whole-degree limit; limit sits at the top eight bits
  function automatic logic t_gt(input logic [9:0] val, input logic [7:0] lim);
    t_gt = $signed(val) > $signed({lim, 2'b00});
  endfunction

  // Sequencer and averager
  tolm_sched #(
    .REMOTE_CYC     (REMOTE_CYC),
    .LOCAL_CYC      (LOCAL_CYC),
    .VOLT_CYC       (VOLT_CYC),
    .REMOTE_AVG_CYC (REMOTE_AVG_CYC),
    .LOCAL_AVG_CYC  (LOCAL_AVG_CYC),
    .VOLT_AVG_CYC   (VOLT_AVG_CYC),
    .ROUND_CYC      (ROUND_CYC),
    .ROUND_AVG_CYC  (ROUND_AVG_CYC)
  ) u_sched (
    .i_clock     (i_clock),
    .i_rst       (i_rst),
    .i_avg_off   (r_r.cfg2[`TOLM_CFG2_AVG_OFF]), // see (R12)
    .i_single    (r_r.cfg2[`TOLM_CFG2_SINGLE]), // see (R14)
    .i_sel_code  (r_r.fan1_hi[7:5]), // see (R15)
    .i_adc_data  (i_adc_data),
    .o_adc_start (o_adc_start),
    .o_adc_chan  (o_adc_chan),
    .cif         (cif.sched)
  );

  tolm_avg u_avg (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .cif     (cif.avg)
  );

  // Register writes, status reads, result handling
  always_comb begin
    r_nxt = r_r;
    v_t = 10'h000;
    v_v = 8'h00;
    idx = 2'd0;
    hyst = 4'h0;
    hi = 1'b0;
    lo = 1'b0;
    above = 1'b0;
    below = 1'b0;

    // Writes; value and status registers are read only
    if (i_reg_wr) begin
      case (i_reg_addr)
        `TOLM_A_V25_LO:  r_nxt.v25_lo = i_reg_wdata;
        `TOLM_A_V25_HI:  r_nxt.v25_hi = i_reg_wdata;
        `TOLM_A_VCC_LO:  r_nxt.vcc_lo = i_reg_wdata;
        `TOLM_A_VCC_HI:  r_nxt.vcc_hi = i_reg_wdata;
        `TOLM_A_R1_LO:   r_nxt.tlo[0] = i_reg_wdata;
        `TOLM_A_R1_HI:   r_nxt.thi[0] = i_reg_wdata;
        `TOLM_A_LT_LO:   r_nxt.tlo[1] = i_reg_wdata;
        `TOLM_A_LT_HI:   r_nxt.thi[1] = i_reg_wdata;
        `TOLM_A_R2_LO:   r_nxt.tlo[2] = i_reg_wdata;
        `TOLM_A_R2_HI:   r_nxt.thi[2] = i_reg_wdata;
        `TOLM_A_FAN1_HI: r_nxt.fan1_hi = i_reg_wdata;
        `TOLM_A_R1_TRIP: r_nxt.trip[0] = i_reg_wdata;
        `TOLM_A_LT_TRIP: r_nxt.trip[1] = i_reg_wdata;
        `TOLM_A_R2_TRIP: r_nxt.trip[2] = i_reg_wdata;
        `TOLM_A_HYST_A:  r_nxt.hyst_a = i_reg_wdata;
        `TOLM_A_HYST_B:  r_nxt.hyst_b = i_reg_wdata;
        `TOLM_A_R1_OFFS: r_nxt.offs[0] = i_reg_wdata;
        `TOLM_A_LT_OFFS: r_nxt.offs[1] = i_reg_wdata;
        `TOLM_A_R2_OFFS: r_nxt.offs[2] = i_reg_wdata;
        `TOLM_A_CFG2:    r_nxt.cfg2 = i_reg_wdata;
        `TOLM_A_CFG3:    r_nxt.cfg3 = i_reg_wdata;
        default: ;
      endcase
    end

    // Reads; data is registered and held between reads
    if (i_reg_rd) begin
      case (i_reg_addr)
        `TOLM_A_V25_VAL: r_nxt.rdata = r_r.volt[0];
        `TOLM_A_VCC_VAL: r_nxt.rdata = r_r.volt[1];
        `TOLM_A_R1_VAL:  r_nxt.rdata = r_r.temp[0][9:2];
        `TOLM_A_LT_VAL:  r_nxt.rdata = r_r.temp[1][9:2];
        `TOLM_A_R2_VAL:  r_nxt.rdata = r_r.temp[2][9:2];
        `TOLM_A_EXT:     r_nxt.rdata = {r_r.temp[2][1:0], r_r.temp[1][1:0],
                                        r_r.temp[0][1:0], 2'b00}; // see (R18)
        `TOLM_A_STAT1:   r_nxt.rdata = {r_r.ovt, r_r.stat[4:2], 1'b0, r_r.stat[1],
                                        1'b0, r_r.stat[0]}; // see (R17)
        `TOLM_A_STAT2:   r_nxt.rdata = {6'h00, r_r.ovt, 1'b0};
        `TOLM_A_V25_LO:  r_nxt.rdata = r_r.v25_lo;
        `TOLM_A_V25_HI:  r_nxt.rdata = r_r.v25_hi;
        `TOLM_A_VCC_LO:  r_nxt.rdata = r_r.vcc_lo;
        `TOLM_A_VCC_HI:  r_nxt.rdata = r_r.vcc_hi;
        `TOLM_A_R1_LO:   r_nxt.rdata = r_r.tlo[0];
        `TOLM_A_R1_HI:   r_nxt.rdata = r_r.thi[0];
        `TOLM_A_LT_LO:   r_nxt.rdata = r_r.tlo[1];
        `TOLM_A_LT_HI:   r_nxt.rdata = r_r.thi[1];
        `TOLM_A_R2_LO:   r_nxt.rdata = r_r.tlo[2];
        `TOLM_A_R2_HI:   r_nxt.rdata = r_r.thi[2];
        `TOLM_A_FAN1_HI: r_nxt.rdata = r_r.fan1_hi;
        `TOLM_A_R1_TRIP: r_nxt.rdata = r_r.trip[0];
        `TOLM_A_LT_TRIP: r_nxt.rdata = r_r.trip[1];
        `TOLM_A_R2_TRIP: r_nxt.rdata = r_r.trip[2];
        `TOLM_A_HYST_A:  r_nxt.rdata = r_r.hyst_a;
        `TOLM_A_HYST_B:  r_nxt.rdata = r_r.hyst_b;
        `TOLM_A_R1_OFFS: r_nxt.rdata = r_r.offs[0];
        `TOLM_A_LT_OFFS: r_nxt.rdata = r_r.offs[1];
        `TOLM_A_R2_OFFS: r_nxt.rdata = r_r.offs[2];
        `TOLM_A_CFG2:    r_nxt.rdata = r_r.cfg2;
        `TOLM_A_CFG3:    r_nxt.rdata = r_r.cfg3;
        default:         r_nxt.rdata = 8'h00;
      endcase
      // Reading clears only flags whose cause has gone
      if (i_reg_addr == `TOLM_A_STAT1)
        r_nxt.stat = r_r.stat & r_r.ool_now; // see (R20)
      if (i_reg_addr == `TOLM_A_STAT2)
        r_nxt.ovt = r_r.ovt & (|r_r.above_trip); // see (R20)
    end

    // New result; sets come after clears so a set in the same cycle wins
    if (cif.r_valid) begin
      if (cif.r_code[2] && cif.r_code[1:0] != 2'd0) begin
        idx = cif.r_code[1:0] - 2'd1;
        v_t = add_offs(cif.r_data, r_r.offs[idx]); // see (R1), (R21)
        r_nxt.temp[idx] = v_t; // see (R18)
        hi = t_gt(v_t, r_r.thi[idx]); // see (R19)
        lo = !t_gt(v_t, r_r.tlo[idx]); // see (R19)
        // Widen first: a two-bit sum would fold remote 2 onto the 2.5 V flag
        r_nxt.ool_now[{1'b0, idx} + 3'd2] = hi | lo; // see (R3)
        if (hi | lo)
          r_nxt.stat[{1'b0, idx} + 3'd2] = 1'b1; // see (R3), (R17)
        // Hysteresis nibbles: remote 1 high, local low, remote 2 high
        case (idx)
          2'd0:    hyst = r_r.hyst_a[7:4]; // see (R9)
          2'd1:    hyst = r_r.hyst_a[3:0]; // see (R9)
          default: hyst = r_r.hyst_b[7:4]; // see (R9)
        endcase
        above = t_gt(v_t, r_r.trip[idx]); // see (R6), (R21)
        below = $signed({v_t[9], v_t}) <
                $signed({$signed({r_r.trip[idx][7], r_r.trip[idx]}) -
                         $signed({5'h00, hyst}), 2'b00}); // see (R7)
        r_nxt.above_trip[idx] = above;
        if (above) begin
          r_nxt.trip_hold[idx] = 1'b1; // see (R6)
          r_nxt.ovt = 1'b1;
        end else if (below || r_r.cfg3[`TOLM_CFG3_OVR]) begin
          r_nxt.trip_hold[idx] = 1'b0; // see (R7), (R8)
        end
      end else if (cif.r_code == `TOLM_CODE_V25 || cif.r_code == `TOLM_CODE_VCC) begin
        idx = {1'b0, cif.r_code[1]};
        v_v = cif.r_data[9:2];
        r_nxt.volt[idx[0]] = v_v;
        hi = idx[0] ? (v_v > r_r.vcc_hi) : (v_v > r_r.v25_hi); // see (R16), (R19)
        lo = idx[0] ? (v_v <= r_r.vcc_lo) : (v_v <= r_r.v25_lo); // see (R16), (R19)
        r_nxt.ool_now[idx] = hi | lo;
        if (hi | lo)
          r_nxt.stat[idx] = 1'b1; // see (R17)
      end
    end

    // Outputs are taken from the updated state and register on the same clock as it
    r_nxt.alert_n = !((|r_nxt.stat) | r_nxt.ovt); // see (R4), (R17)
    r_nxt.fan_full = i_auto_fan_mode & (|r_nxt.trip_hold); // see (R6)
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_r <= '0;
      r_r.v25_lo <= `TOLM_RST_VLO; // see (R16)
      r_r.v25_hi <= `TOLM_RST_VHI; // see (R16)
      r_r.vcc_lo <= `TOLM_RST_VLO; // see (R16)
      r_r.vcc_hi <= `TOLM_RST_VHI; // see (R16)
      r_r.fan1_hi <= `TOLM_RST_FAN1_HI;
      r_r.cfg2 <= `TOLM_RST_CFG; // see (R11)
      r_r.cfg3 <= `TOLM_RST_CFG;
      r_r.hyst_a <= `TOLM_RST_HYST_A; // see (R9)
      r_r.hyst_b <= `TOLM_RST_HYST_B; // see (R9)
      r_r.tlo <= {3{`TOLM_RST_TLO}}; // see (R5)
      r_r.thi <= {3{`TOLM_RST_THI}}; // see (R5)
      r_r.trip <= {3{`TOLM_RST_TRIP}}; // see (R10)
      r_r.offs <= {3{`TOLM_RST_OFFS}}; // see (R2)
      r_r.temp <= {3{`TOLM_RST_TVAL}};
      r_r.alert_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs straight from flops
  assign o_reg_rdata      = r_r.rdata;
  assign o_smbalert_n     = r_r.alert_n;
  assign o_fan_full_speed = r_r.fan_full;
endmodule // tolm_monitor

// ### tolm_consts.svh
// Register offsets, reset values, field positions and timing figures of the monitor
`ifndef TOLM_CONSTS_SVH
`define TOLM_CONSTS_SVH
// Register offsets
`define TOLM_A_V25_VAL   8'h20
`define TOLM_A_VCC_VAL   8'h22
`define TOLM_A_R1_VAL    8'h25
`define TOLM_A_LT_VAL    8'h26
`define TOLM_A_R2_VAL    8'h27
`define TOLM_A_STAT1     8'h41
`define TOLM_A_STAT2     8'h42
`define TOLM_A_V25_LO    8'h44
`define TOLM_A_V25_HI    8'h45
`define TOLM_A_VCC_LO    8'h48
`define TOLM_A_VCC_HI    8'h49
`define TOLM_A_R1_LO     8'h4e
`define TOLM_A_R1_HI     8'h4f
`define TOLM_A_LT_LO     8'h50
`define TOLM_A_LT_HI     8'h51
`define TOLM_A_R2_LO     8'h52
`define TOLM_A_R2_HI     8'h53
`define TOLM_A_FAN1_HI   8'h55
`define TOLM_A_R1_TRIP   8'h6a
`define TOLM_A_LT_TRIP   8'h6b
`define TOLM_A_R2_TRIP   8'h6c
`define TOLM_A_HYST_A    8'h6d
`define TOLM_A_HYST_B    8'h6e
`define TOLM_A_R1_OFFS   8'h70
`define TOLM_A_LT_OFFS   8'h71
`define TOLM_A_R2_OFFS   8'h72
`define TOLM_A_CFG2      8'h73
`define TOLM_A_EXT       8'h77
`define TOLM_A_CFG3      8'h78
// Reset values
`define TOLM_RST_TLO     8'h81
`define TOLM_RST_THI     8'h7f
`define TOLM_RST_TRIP    8'h64
`define TOLM_RST_VLO     8'h00
`define TOLM_RST_VHI     8'hff
`define TOLM_RST_FAN1_HI 8'hff
`define TOLM_RST_HYST_A  8'h44
`define TOLM_RST_HYST_B  8'h40
`define TOLM_RST_OFFS    8'h00
`define TOLM_RST_CFG     8'h00
`define TOLM_RST_TVAL    10'h200
// Field positions
`define TOLM_CFG2_AVG_OFF 4
`define TOLM_CFG2_SINGLE  6
`define TOLM_CFG3_OVR     2
// Channel codes of the converter
`define TOLM_CODE_V25    3'h0
`define TOLM_CODE_VCC    3'h2
`define TOLM_CODE_R1     3'h5
`define TOLM_CODE_LT     3'h6
`define TOLM_CODE_R2     3'h7
// Timing figures in ns and clock period
`define TOLM_CLK_NS      50
`define TOLM_AVG_SAMPLES 16
`define TOLM_REMOTE_NS   4000000
`define TOLM_LOCAL_NS    1400000
`define TOLM_VOLT_NS     711000
`define TOLM_REMOTE_AVG_NS 25500000
`define TOLM_LOCAL_AVG_NS  12000000
`define TOLM_VOLT_AVG_NS   11380000
`define TOLM_ROUND_NS      15500000
`define TOLM_ROUND_AVG_NS  120000000
`endif

// ### tolm_pkg.sv
// Types shared by the monitor modules
package tolm_pkg;
  typedef enum logic [2:0] {
    SC_START = 3'b001,
    SC_CONV  = 3'b010,
    SC_GAP   = 3'b100
  } tolm_sched_e;
  typedef struct packed {
    tolm_sched_e st;
    logic [2:0]  idx;
    logic [3:0]  cnt;
    logic [21:0] slot;
    logic [21:0] round;
    logic        start;
    logic [2:0]  code;
    logic        s_valid;
    logic [9:0]  s_data;
    logic        s_first;
    logic        s_last;
  } tolm_sched_s;
  typedef struct packed {
    logic [13:0] acc;
    logic        r_valid;
    logic [2:0]  r_code;
    logic [9:0]  r_data;
  } tolm_avg_s;
  typedef struct packed {
    logic [7:0]       v25_lo, v25_hi, vcc_lo, vcc_hi;
    logic [7:0]       fan1_hi, cfg2, cfg3, hyst_a, hyst_b;
    logic [2:0][7:0]  tlo, thi, trip, offs;
    logic [2:0][9:0]  temp;
    logic [1:0][7:0]  volt;
    logic [4:0]       ool_now;
    logic [4:0]       stat;
    logic [2:0]       above_trip;
    logic [2:0]       trip_hold;
    logic             ovt;
    logic [7:0]       rdata;
    logic             alert_n;
    logic             fan_full;
  } tolm_core_s;
endpackage

// ### tolm_conv_if.sv
// Sample and result path between scheduler, averager and core
`timescale 1ns/1ns
interface tolm_conv_if;
  logic       s_valid;
  logic [2:0] s_code;
  logic [9:0] s_data;
  logic       s_first;
  logic       s_last;
  logic       r_valid;
  logic [2:0] r_code;
  logic [9:0] r_data;
  modport sched (output s_valid, s_code, s_data, s_first, s_last);
  modport avg   (input s_valid, s_code, s_data, s_first, s_last,
                 output r_valid, r_code, r_data);
  modport core  (input r_valid, r_code, r_data);
endinterface

// ### tolm_sched.sv
// Conversion sequencer: round robin or single channel, averaged or not
`timescale 1ns/1ns
`include "tolm_consts.svh"
module tolm_sched #(
  parameter int REMOTE_CYC = 80000, LOCAL_CYC = 28000, VOLT_CYC = 14220,
  parameter int REMOTE_AVG_CYC = 31875, LOCAL_AVG_CYC = 15000, VOLT_AVG_CYC = 14225,
  parameter int ROUND_CYC = 310000, ROUND_AVG_CYC = 2400000
) (
  // Clock and reset
  input  logic       i_clock,
  input  logic       i_rst,
  // Mode and converter
  input  logic       i_avg_off,
  input  logic       i_single,
  input  logic [2:0] i_sel_code,
  input  logic [9:0] i_adc_data,
  output logic       o_adc_start,
  output logic [2:0] o_adc_chan,
  // Samples out
  tolm_conv_if.sched cif
);
  tolm_pkg::tolm_sched_s r_r, r_nxt;
  logic [21:0] slot_len;

  // Round order: 2.5 V, Vcc, remote 1, local, remote 2
  function automatic logic [2:0] idx2code(input logic [2:0] i);
    case (i)
      3'd0:    idx2code = `TOLM_CODE_V25;
      3'd1:    idx2code = `TOLM_CODE_VCC;
      3'd2:    idx2code = `TOLM_CODE_R1;
      3'd3:    idx2code = `TOLM_CODE_LT;
      default: idx2code = `TOLM_CODE_R2;
    endcase
  endfunction

  // Per-sample slot; averaged slots are the channel time over 16 samples
  always_comb begin
    if (!r_r.code[2])
      slot_len = i_avg_off ? 22'(VOLT_CYC) : 22'(VOLT_AVG_CYC); // see (R13)
    else if (r_r.code == `TOLM_CODE_LT)
      slot_len = i_avg_off ? 22'(LOCAL_CYC) : 22'(LOCAL_AVG_CYC); // see (R13)
    else
      slot_len = i_avg_off ? 22'(REMOTE_CYC) : 22'(REMOTE_AVG_CYC); // see (R13)
  end

  // Sequencer
  always_comb begin
    r_nxt = r_r;
    r_nxt.start = 1'b0;
    r_nxt.s_valid = 1'b0;
    r_nxt.round = r_r.round + 22'd1;
    case (r_r.st)
      tolm_pkg::SC_START: begin
        r_nxt.start = 1'b1;
        r_nxt.code = i_single ? i_sel_code : idx2code(r_r.idx); // see (R14), (R15)
        r_nxt.slot = 22'd0;
        r_nxt.st = tolm_pkg::SC_CONV;
      end
      tolm_pkg::SC_CONV: begin
        r_nxt.slot = r_r.slot + 22'd1;
        if (r_r.slot >= slot_len - 22'd1) begin
          r_nxt.s_valid = 1'b1;
          r_nxt.s_data = i_adc_data;
          r_nxt.s_first = (r_r.cnt == 4'd0);
          r_nxt.s_last = i_avg_off || (r_r.cnt == 4'(`TOLM_AVG_SAMPLES - 1)); // see (R11), (R12)
          r_nxt.st = tolm_pkg::SC_START;
          r_nxt.cnt = r_r.cnt + 4'd1;
          if (r_nxt.s_last) begin
            r_nxt.cnt = 4'd0;
            if (!i_single && r_r.idx == 3'd4) begin
              r_nxt.idx = 3'd0;
              r_nxt.st = tolm_pkg::SC_GAP;
            end else if (!i_single) begin
              r_nxt.idx = r_r.idx + 3'd1;
            end
          end
        end
      end
      tolm_pkg::SC_GAP: begin
        // Next round starts a fixed period after the last one began
        if (r_r.round >= (i_avg_off ? 22'(ROUND_CYC - 1) : 22'(ROUND_AVG_CYC - 1))) begin // see (R12)
          r_nxt.round = 22'd0;
          r_nxt.st = tolm_pkg::SC_START;
        end
      end
      default: r_nxt.st = tolm_pkg::SC_START;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      r_r <= '0;
      r_r.st <= tolm_pkg::SC_START;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_adc_start = r_r.start;
  assign o_adc_chan  = r_r.code;
  assign cif.s_valid = r_r.s_valid;
  assign cif.s_code  = r_r.code;
  assign cif.s_data  = r_r.s_data;
  assign cif.s_first = r_r.s_first;
  assign cif.s_last  = r_r.s_last;
endmodule // tolm_sched

// ### tolm_avg.sv
// Sixteen-sample averager; a lone sample passes through unchanged
`timescale 1ns/1ns
module tolm_avg (
  // Clock and reset
  input  logic   i_clock,
  input  logic   i_rst,
  // Samples in, results out
  tolm_conv_if.avg cif
);
  tolm_pkg::tolm_avg_s r_r, r_nxt;
  logic [13:0] ext;
  logic [13:0] sum;

  // Temperatures are signed, voltages unsigned
  always_comb begin
    ext = cif.s_code[2] ? {{4{cif.s_data[9]}}, cif.s_data} : {4'h0, cif.s_data};
    sum = (cif.s_first ? 14'h0000 : r_r.acc) + ext;
    r_nxt = r_r;
    r_nxt.r_valid = 1'b0;
    if (cif.s_valid) begin
      r_nxt.acc = sum;
      if (cif.s_last) begin
        r_nxt.r_valid = 1'b1;
        r_nxt.r_code = cif.s_code;
        r_nxt.r_data = cif.s_first ? cif.s_data : sum[13:4]; // see (R11), (R12)
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign cif.r_valid = r_r.r_valid;
  assign cif.r_code  = r_r.r_code;
  assign cif.r_data  = r_r.r_data;
endmodule // tolm_avg

// ### tolm_monitor_props.sv
// Port-level assertions for the temperature monitor
`timescale 1ns/1ns
module tolm_monitor_chk (
  // Clock, reset and register port
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  // Converter, fan and alert
  input wire logic       o_adc_start,
  input wire logic [2:0] o_adc_chan,
  input wire logic       i_auto_fan_mode,
  input wire logic       o_fan_full_speed,
  input wire logic       o_smbalert_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Offset written, one idle cycle, then read back
  sequence s_wr_offs;
    i_reg_wr && i_reg_addr == 8'h70 ##2 i_reg_rd && !i_reg_wr && i_reg_addr == 8'h70;
  endsequence
  // Shortest slot still leaves two quiet cycles
  sequence s_quiet;
    !o_adc_start [*2];
  endsequence
  chk_reset_quiet: assert property (
    disable iff (1'b0) i_rst |=> o_reg_rdata == 8'h00 && o_smbalert_n && !o_fan_full_speed)
    else $error("outputs busy in reset");
  chk_start_pulse: assert property (o_adc_start |=> s_quiet)
    else $error("start pulse too long");
  chk_chan_hold: assert property (
    o_adc_start |=> $stable(o_adc_chan) [*2]) else $error("channel moved in slot");
  chk_rdata_hold: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata)) else $error("read data moved");
  chk_fan_auto: assert property (
    !i_auto_fan_mode |=> !o_fan_full_speed) else $error("fan forced in manual mode");
  chk_gap_read: assert property (
    i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata == 8'h00) else $error("gap read not zero");
  chk_alert_read: assert property (
    $rose(o_smbalert_n) |-> $past(i_reg_rd) || $past(i_reg_rd, 2)) else $error("alert unread");
  chk_offs_back: assert property (
    s_wr_offs |=> o_reg_rdata == $past(i_reg_wdata, 3)) else $error("offset readback wrong");
endmodule // tolm_monitor_chk
bind tolm_monitor tolm_monitor_chk u_chk (.i_clock, .i_rst, .i_reg_addr, .i_reg_wr, .i_reg_rd,
  .i_reg_wdata, .o_reg_rdata, .o_adc_start, .o_adc_chan, .i_auto_fan_mode, .o_fan_full_speed,
  .o_smbalert_n);

// ### tolm_adc_model.sv
// Converter model: one reading per channel code, optional dither
`timescale 1ns/1ns
module tolm_adc_model (
  // Clock and request
  input  wire logic       i_clock,
  input  wire logic       i_start,
  input  wire logic [2:0] i_chan,
  // Scene set by the bench
  input  wire logic [9:0] i_base [8],
  input  wire logic       i_dither,
  // Sample back
  output logic [9:0]      o_data
);
  logic tog_r = 1'b0;
  // Flip per conversion so an average differs from any single sample
  always @(posedge i_clock) begin
    if (i_start) begin
      tog_r <= ~tog_r;
    end
  end
  // Two's complement reading, quarter degree steps
  assign o_data = i_base[i_chan] + ((i_dither && tog_r) ? 10'h004 : 10'h000);
endmodule // tolm_adc_model

// ### testbench.sv
// Self-checking bench for the temperature monitor
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, auto_fan = 1'b0, dith = 1'b1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic [9:0] base [8] = '{10'h200, 10'h000, 10'h200, 10'h000, 10'h000, 10'h0c8, 10'h064,
                           10'h0c8};
  logic [15:0] rv [19] = '{16'h4e81, 16'h4f7f, 16'h5081, 16'h517f, 16'h5281, 16'h537f,
    16'h6a64, 16'h6b64, 16'h6c64, 16'h6d44, 16'h6e40, 16'h7000, 16'h7100, 16'h7200,
    16'h4400, 16'h45ff, 16'h4800, 16'h49ff, 16'h0000};
  logic       start, fan, alrt_n;
  logic [2:0] chan;
  logic [9:0] adc;
  int         err_total = 0;
  int         checked = 0;
  int         n;
  // 20 MHz clock
  always #25 clk = ~clk;
  // Short slots keep the run small
  tolm_monitor #(.REMOTE_CYC(8), .LOCAL_CYC(6), .VOLT_CYC(4), .REMOTE_AVG_CYC(4),
    .LOCAL_AVG_CYC(3), .VOLT_AVG_CYC(3), .ROUND_CYC(200), .ROUND_AVG_CYC(800)) uut (
    .i_clock(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
    .i_reg_rd(rd), .o_reg_rdata(rdat), .o_adc_start(start), .o_adc_chan(chan),
    .i_adc_data(adc), .i_auto_fan_mode(auto_fan), .o_fan_full_speed(fan),
    .o_smbalert_n(alrt_n));
  tolm_adc_model u_adc (.i_clock(clk), .i_start(start), .i_chan(chan), .i_base(base),
    .i_dither(dith), .o_data(adc));
  // Compare and count
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle write strobe
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle read strobe, data settled a cycle later
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp(rdat, e);
  endtask
  // Whole unaveraged rounds, ending mid-cycle
  task automatic rounds(input int k);
    repeat (k * 200) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 19; i++) begin
      rreg(rv[i][15:8], rv[i][7:0]);
    end
    rounds(8);
    rreg(8'h25, 8'h32);
    rreg(8'h77, 8'ha8);
    @(posedge clk);
    dith <= 1'b0;
    wreg(8'h73, 8'h10);
    wreg(8'h70, 8'hfc);
    rreg(8'h70, 8'hfc);
    wreg(8'h71, 8'h10);
    rounds(6);
    rreg(8'h25, 8'h31);
    rreg(8'h26, 8'h1d);
    rreg(8'h41, 8'h00);
    wreg(8'h4f, 8'h31);
    rounds(2);
    rreg(8'h41, 8'h00);
    wreg(8'h4f, 8'h30);
    rounds(2);
    cmp({7'h00, alrt_n}, 8'h00);
    rreg(8'h41, 8'h10);
    wreg(8'h4f, 8'h7f);
    rounds(2);
    rreg(8'h41, 8'h10);
    rreg(8'h41, 8'h00);
    cmp({7'h00, alrt_n}, 8'h01);
    wreg(8'h4e, 8'h31);
    wreg(8'h45, 8'h7f);
    rounds(2);
    rreg(8'h41, 8'h11);
    @(posedge clk);
    auto_fan <= 1'b1;
    wreg(8'h6a, 8'h30);
    rounds(2);
    cmp({7'h00, fan}, 8'h01);
    wreg(8'h6a, 8'h32);
    rounds(2);
    cmp({7'h00, fan}, 8'h01);
    wreg(8'h6d, 8'h04);
    rounds(2);
    cmp({7'h00, fan}, 8'h00);
    wreg(8'h6d, 8'h44);
    wreg(8'h78, 8'h04);
    wreg(8'h6a, 8'h30);
    rounds(2);
    cmp({7'h00, fan}, 8'h01);
    wreg(8'h6a, 8'h32);
    rounds(2);
    cmp({7'h00, fan}, 8'h00);
    wreg(8'h6a, 8'h30);
    rounds(2);
    @(posedge clk);
    auto_fan <= 1'b0;
    rounds(1);
    cmp({7'h00, fan}, 8'h00);
    wreg(8'h73, 8'h50);
    // New scene per channel: 64 C plus that channel's offset lands in its value register
    for (int c = 5; c < 8; c++) begin
      wreg(8'h55, {c[2:0], 5'h1f});
      base[c] <= 10'h100;
      repeat (250) @(posedge clk);
      n = 0;
      repeat (100) begin
        @(negedge clk);
        if (start) begin
          n++;
          cmp({5'h00, chan}, {5'h00, c[2:0]});
        end
      end
      cmp({7'h00, n > 0}, 8'h01);
      rreg(8'h20 + 8'(c), (c == 5) ? 8'h3f : ((c == 6) ? 8'h44 : 8'h40));
    end
    // Remote 2 above its high limit must raise its own flag, not another's
    wreg(8'h53, 8'h3f);
    repeat (50) @(posedge clk);
    rreg(8'h41, 8'hd1);
    give_verdict();
  end
endmodule // testbench
